// ### sfcf_pkg.sv
// Shared constants and types of the serial flash command front end
package sfcf_pkg;

  // Opcodes
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OPC_PAGE_PROGRAM_CMD = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE_CMD = 8'h20;
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK_ERASE_CMD = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OPC_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_DUAL_READ = 8'h3b;
  localparam logic [7:0] OPC_ENTER_DEEP_SLEEP_CMD = 8'hb9;
  localparam logic [7:0] OPC_WAKE_AND_READ_IDENT_CMD = 8'hab;
  localparam logic [7:0] OPC_MAKER_DEVICE = 8'h90;
  localparam logic [7:0] OPC_JEDEC_IDENT = 8'h9f;

  // Byte counts within a frame (bytes completed so far)
  localparam logic [8:0] BYTES_OPCODE = 9'h001;
  localparam logic [8:0] BYTES_ADDR_LAST = 9'h003;
  localparam logic [8:0] BYTES_ADDR_END = 9'h004;
  localparam logic [8:0] BYTES_DUMMY_END = 9'h005;
  localparam logic [8:0] BYTES_STATUS_WRITE_MIN = 9'h002;
  localparam logic [8:0] BYTES_PROGRAM_MIN = 9'h005;
  localparam logic [8:0] BYTES_IDENT_START = 9'h004;
  localparam logic [8:0] BYTES_JEDEC_LAST = 9'h003;
  localparam logic [8:0] BYTES_MAX = 9'h1ff;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] DUAL_LAST = 2'h3;

  // Status byte layout
  localparam int STS_BUSY = 0;
  localparam int STS_WRITE_ENABLE_LATCH = 1;
  localparam int STS_BLOCK_PROTECT_LO = 2;
  localparam int STS_BLOCK_PROTECT_HI = 4;
  localparam int STS_LOCK = 7;

  // Values after reset
  localparam logic STATUS_LOCK_RST = 1'b0;
  localparam logic [2:0] BLOCK_PROTECT_RST = 3'h0;
  localparam logic WRITE_ENABLE_LATCH_RST = 1'b0;

  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_STATUS_WRITE,
    OPK_PROGRAM,
    OPK_ERASE_4K,
    OPK_ERASE_32K,
    OPK_ERASE_64K,
    OPK_ERASE_CHIP
  } sfcf_op_kind_t;

  typedef enum logic [1:0] {
    MODE_READY,
    MODE_BUSY,
    MODE_SLEEP
  } sfcf_mode_t;

  typedef struct packed {
    sfcf_op_kind_t kind;
    logic [23:0] addr;
    logic [8:0] len;
  } sfcf_op_req_t;

  typedef struct packed {
    logic zeroOut;
    logic zeroOe;
    logic oneOut;
    logic oneOe;
  } sfcf_lanes_t;

endpackage

// ### sfcf_sync.sv
// Two-flop level synchroniser
module sfcf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [W-1:0] d, // Level from another domain
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### sfcf_page_mem.sv
// Page buffer: written on the link clock, read on the system clock
module sfcf_page_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  input wire logic wrClk, // Write clock
  input wire logic write_enable_cmd, // Write strobe
  input wire logic [AW-1:0] wrAddr, // Write address
  input wire logic [DW-1:0] wrData, // Write data
  input wire logic rdClk, // Read clock
  input wire logic [AW-1:0] rdAddr, // Read address
  output logic [DW-1:0] rdData // Registered read data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wrClk) begin
    if (write_enable_cmd) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge rdClk) begin
    rdData <= mem[rdAddr];
  end
endmodule

// ### sfcf_front_end.sv
// Serial command front end of a small serial NOR flash
module sfcf_front_end #(
  parameter logic [7:0] MAKER_ID = 8'ha5, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3c, // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h77, // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h0e // Arbitrary value
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sclk, // Serial clock from host
  input wire logic csN, // Chip select, active low
  input wire logic serialInLine, // Serial input, lane zero in
  output sfcf_pkg::sfcf_lanes_t lanes, // Lane outputs and enables
  output logic [23:0] arrRdAddr, // Array read address, link domain
  input wire logic [7:0] arrRdData, // Array read data, link domain
  output sfcf_pkg::sfcf_op_req_t opReq, // Internal operation request
  output logic opStart, // Operation start pulse
  input wire logic opDone, // Operation finished pulse
  input wire logic [7:0] pageRdAddr, // Page buffer read address
  output logic [7:0] pageRdData, // Page buffer read data
  output logic [7:0] statusByte, // Status byte
  output logic deviceActive, // High while not in standby
  output logic deepSleep // High in deep sleep
);
  import sfcf_pkg::*;

  // ---------------- Link domain (sclk, bit and byte counters, shift register and lanes cleared while deselected) ----------------
  logic [2:0] bitIdx_q;
  logic [8:0] byteCnt_q;
  logic [31:0] shift_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] data_q;
  logic [8:0] pgCnt_q;
  logic [1:0] dualCnt_q;
  logic [23:0] rdAddr_q;
  logic [8:0] linkSyncIn;
  logic [8:0] linkSync;
  logic [7:0] linkStatus;
  logic linkSleep;
  logic linkBusy;
  logic [2:0] frBit_q;
  logic [8:0] frBytes_q;

  // Output gating by device mode
  wire logic txAllowed = linkSleep ? (op_q == OPC_WAKE_AND_READ_IDENT_CMD)
                       : (linkBusy ? (op_q == OPC_READ_STATUS) : 1'b1);

  wire logic [7:0] inByte = {shift_q[6:0], serialInLine};
  wire logic byteEnd = (bitIdx_q == BIT_LAST);
  wire logic opKnown = (byteCnt_q >= BYTES_OPCODE);
  wire logic isDual = (op_q == OPC_DUAL_READ);
  wire logic dualPhase = isDual && (byteCnt_q >= BYTES_DUMMY_END) && txAllowed;
  wire logic pgWrEn = (op_q == OPC_PAGE_PROGRAM_CMD) && byteEnd && (byteCnt_q >= BYTES_ADDR_END);
  wire logic [7:0] pgWrAddr = addr_q[7:0] + pgCnt_q[7:0];
  wire logic [2:0] bitIdx_d = dualPhase ? bitIdx_q : bitIdx_q + 3'h1;
  wire logic [8:0] byteCnt_d = (byteEnd && !dualPhase && byteCnt_q != BYTES_MAX)
                             ? byteCnt_q + 9'h001 : byteCnt_q;

  // Byte to send and whether this opcode is in its data phase
  logic [7:0] txByte;
  logic txPhase;
  wire logic mfrFirst = (byteCnt_q[0] ^ addr_q[0]) == 1'b0;

  always_comb begin
    txByte = 8'h00;
    txPhase = 1'b0;
    case (op_q)
      OPC_READ_STATUS: begin
        txByte = linkStatus;
        txPhase = opKnown;
      end
      OPC_WAKE_AND_READ_IDENT_CMD: begin
        txByte = DEVICE_ID;
        txPhase = (byteCnt_q >= BYTES_IDENT_START);
      end
      OPC_MAKER_DEVICE: begin
        txByte = mfrFirst ? MAKER_ID : DEVICE_ID;
        txPhase = (byteCnt_q >= BYTES_IDENT_START);
      end
      OPC_JEDEC_IDENT: begin
        txPhase = opKnown && (byteCnt_q <= BYTES_JEDEC_LAST);
        case (byteCnt_q[1:0])
          2'h1: txByte = MAKER_ID;
          2'h2: txByte = MEM_TYPE;
          default: txByte = CAPACITY;
        endcase
      end
      OPC_READ: begin
        txByte = arrRdData;
        txPhase = (byteCnt_q >= BYTES_ADDR_END);
      end
      OPC_FAST_READ, OPC_DUAL_READ: begin
        txByte = arrRdData;
        txPhase = (byteCnt_q >= BYTES_DUMMY_END);
      end
      default: begin
        txByte = 8'h00;
        txPhase = 1'b0;
      end
    endcase
  end

  wire logic txEn = opKnown && txAllowed && txPhase;
  wire logic arrStep = txEn && (op_q == OPC_READ || op_q == OPC_FAST_READ) && byteEnd;
  wire logic dualStep = dualPhase && (dualCnt_q == DUAL_LAST);
  wire logic [2:0] singleSel = BIT_LAST - bitIdx_q;
  wire logic [2:0] dualSelOdd = {~dualCnt_q, 1'b1};
  wire logic [2:0] dualSelEven = {~dualCnt_q, 1'b0};

  // Bit and byte counters; select high clears them between frames
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitIdx_q <= 3'h0;
      byteCnt_q <= 9'h000;
      shift_q <= 32'h0000_0000;
    end else begin
      shift_q <= {shift_q[30:0], serialInLine};
      bitIdx_q <= bitIdx_d;
      byteCnt_q <= byteCnt_d;
    end
  end

  // Frame end counts, kept after select rises for the system side
  always_ff @(posedge sclk) begin
    frBit_q <= bitIdx_d;
    frBytes_q <= byteCnt_d;
  end

  // Opcode, address and last data byte capture; held between frames
  always_ff @(posedge sclk) begin
    if (byteEnd && byteCnt_q == 9'h000) begin
      op_q <= inByte;
    end
    if (byteEnd && byteCnt_q == BYTES_ADDR_LAST) begin
      addr_q <= {shift_q[22:0], serialInLine};
    end
    if (byteEnd && opKnown) begin
      data_q <= inByte;
    end
  end

  // Read address and page data counters; page count restarts each frame
  always_ff @(posedge sclk) begin
    if (byteEnd && byteCnt_q == BYTES_ADDR_LAST) begin
      rdAddr_q <= {shift_q[22:0], serialInLine};
    end else if (arrStep || dualStep) begin
      rdAddr_q <= rdAddr_q + 24'h000001;
    end
    if (byteCnt_q == 9'h000) begin
      pgCnt_q <= 9'h000;
    end else if (pgWrEn && pgCnt_q != PAGE_BYTES) begin
      pgCnt_q <= pgCnt_q + 9'h001;
    end
    dualCnt_q <= dualPhase ? dualCnt_q + 2'h1 : 2'h0;
  end

  // Output lanes change on falling clock edges
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      lanes <= '0;
    end else begin
      lanes.oneOe <= txEn;
      lanes.zeroOe <= txEn && isDual;
      if (isDual) begin
        lanes.oneOut <= txByte[dualSelOdd];
        lanes.zeroOut <= txByte[dualSelEven];
      end else begin
        lanes.oneOut <= txByte[singleSel];
        lanes.zeroOut <= 1'b0;
      end
    end
  end

  assign arrRdAddr = rdAddr_q;

  sfcf_page_mem #(
    .DW(8),
    .AW(8)
  ) u_page (
    .wrClk(sclk),
    .write_enable_cmd(pgWrEn),
    .wrAddr(pgWrAddr),
    .wrData(inByte),
    .rdClk(clk),
    .rdAddr(pageRdAddr),
    .rdData(pageRdData)
  );

  // Mode and status into the link domain
  sfcf_sync #(
    .W(9),
    .RST_VAL(9'h000)
  ) u_link_sync (
    .clk(sclk),
    .rst(1'b0),
    .d(linkSyncIn),
    .q(linkSync)
  );

  assign linkStatus = linkSync[7:0];
  assign linkSleep = linkSync[8];
  assign linkBusy = linkSync[STS_BUSY];

  // ---------------- System domain (clk) ----------------
  logic csSync;
  logic csPrev_q;
  sfcf_mode_t mode_q;
  logic wel_q;
  logic lock_q;
  logic [2:0] bp_q;
  logic opStart_q;
  sfcf_op_req_t opReq_q;

  sfcf_sync #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_cs_sync (
    .clk(clk),
    .rst(rst),
    .d(csN),
    .q(csSync)
  );

  // Link registers are stable once select is high and the clock has stopped
  wire logic csRise = csSync && !csPrev_q;
  wire logic frOpKnown = (frBytes_q >= BYTES_OPCODE);
  wire logic frWhole = (frBit_q == 3'h0) && frOpKnown;
  wire logic isReady = (mode_q == MODE_READY);
  wire logic isBusy = (mode_q == MODE_BUSY);
  wire logic isSleep = (mode_q == MODE_SLEEP);
  wire logic cmdOk = csRise && isReady && frWhole;
  wire logic writeOk = cmdOk && wel_q;
  wire logic addrOk = (frBytes_q >= BYTES_ADDR_END);

  wire logic doWren = cmdOk && op_q == OPC_WRITE_ENABLE_CMD;
  wire logic doWrdi = cmdOk && op_q == OPC_WRITE_DISABLE;
  wire logic doSleep = cmdOk && op_q == OPC_ENTER_DEEP_SLEEP_CMD;
  wire logic doWake = csRise && isSleep && frOpKnown
                    && op_q == OPC_WAKE_AND_READ_IDENT_CMD;
  wire logic doStsWr = writeOk && op_q == OPC_STATUS_WRITE_CMD
                     && frBytes_q >= BYTES_STATUS_WRITE_MIN;
  wire logic doProg = writeOk && op_q == OPC_PAGE_PROGRAM_CMD
                    && frBytes_q >= BYTES_PROGRAM_MIN;
  wire logic doErase4 = writeOk && addrOk && op_q == OPC_SECTOR_ERASE_CMD;
  wire logic doErase32 = writeOk && addrOk && op_q == OPC_HALF_BLOCK_ERASE;
  wire logic doErase64 = writeOk && addrOk && op_q == OPC_BLOCK_ERASE_CMD;
  wire logic doChip = writeOk && (op_q == OPC_CHIP_ERASE || op_q == OPC_CHIP_ERASE_ALT);
  wire logic doStart = doStsWr || doProg || doErase4 || doErase32 || doErase64 || doChip;
  wire logic doFinish = isBusy && opDone;

  sfcf_op_kind_t startKind;
  always_comb begin
    startKind = OPK_NONE;
    if (doStsWr) begin
      startKind = OPK_STATUS_WRITE;
    end else if (doProg) begin
      startKind = OPK_PROGRAM;
    end else if (doErase4) begin
      startKind = OPK_ERASE_4K;
    end else if (doErase32) begin
      startKind = OPK_ERASE_32K;
    end else if (doErase64) begin
      startKind = OPK_ERASE_64K;
    end else if (doChip) begin
      startKind = OPK_ERASE_CHIP;
    end
  end

  // Device mode
  sfcf_mode_t mode_d;
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_READY: begin
        if (doStart) begin
          mode_d = MODE_BUSY;
        end else if (doSleep) begin
          mode_d = MODE_SLEEP;
        end
      end
      MODE_BUSY: begin
        if (opDone) begin
          mode_d = MODE_READY;
        end
      end
      MODE_SLEEP: begin
        if (doWake) begin
          mode_d = MODE_READY;
        end
      end
      default: mode_d = MODE_READY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      csPrev_q <= 1'b1;
      mode_q <= MODE_READY;
    end else begin
      csPrev_q <= csSync;
      mode_q <= mode_d;
    end
  end

  // Write latch and writable status bits
  always_ff @(posedge clk) begin
    if (rst) begin
      wel_q <= WRITE_ENABLE_LATCH_RST;
      lock_q <= STATUS_LOCK_RST;
      bp_q <= BLOCK_PROTECT_RST;
    end else begin
      if (doFinish || doWrdi) begin
        wel_q <= 1'b0;
      end else if (doWren) begin
        wel_q <= 1'b1;
      end
      if (doStsWr) begin
        lock_q <= data_q[STS_LOCK];
        bp_q <= data_q[STS_BLOCK_PROTECT_HI:STS_BLOCK_PROTECT_LO];
      end
    end
  end

  // Request to the array sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      opStart_q <= 1'b0;
      opReq_q <= '0;
    end else begin
      opStart_q <= doStart;
      if (doStart) begin
        opReq_q.kind <= startKind;
        opReq_q.addr <= addr_q;
        opReq_q.len <= pgCnt_q;
      end
    end
  end

  assign statusByte = {lock_q, 2'b00, bp_q, wel_q, isBusy};
  assign linkSyncIn = {isSleep, statusByte};
  assign opStart = opStart_q;
  assign opReq = opReq_q;
  assign deepSleep = isSleep;
  assign deviceActive = !csSync || isBusy;
endmodule

// ### sfcf_front_end_chk.sv
// Port checker of the serial flash command front end
module sfcf_front_end_chk (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic sclk, // Serial clock
  input wire logic csN, // Select, active low
  input wire logic serialInLine, // Serial input
  input wire sfcf_pkg::sfcf_lanes_t lanes, // Lane outputs
  input wire logic [23:0] arrRdAddr, // Array address
  input wire logic [7:0] arrRdData, // Array data
  input wire sfcf_pkg::sfcf_op_req_t opReq, // Operation request
  input wire logic opStart, // Start pulse
  input wire logic opDone, // Done pulse
  input wire logic [7:0] pageRdAddr, // Page read address
  input wire logic [7:0] pageRdData, // Page read data
  input wire logic [7:0] statusByte, // Status byte
  input wire logic deviceActive, // Not in standby
  input wire logic deepSleep // Deep sleep
);
  import sfcf_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_start_busy; opStart |-> statusByte[STS_BUSY]; endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start without busy");
  property p_wel_first; opStart |-> $past(statusByte[STS_WRITE_ENABLE_LATCH]); endproperty
  a_wel_first: assert property (p_wel_first)
    else $error("start without write latch");
  property p_done_clear;
    opDone && statusByte[STS_BUSY] |=> !statusByte[STS_BUSY] && !statusByte[1];
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("busy or latch kept after done");
  property p_busy_hold; statusByte[STS_BUSY] && !opDone |=> statusByte[0] && !opStart; endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("start or idle while busy");
  property p_sleep_block; deepSleep |-> !opStart; endproperty
  a_sleep_block: assert property (p_sleep_block)
    else $error("start in deep sleep");
  property p_oe_release; csN |-> !lanes.oneOe && !lanes.zeroOe; endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("lane driven while deselected");
  property p_active_sel; (!csN) [*4] |-> deviceActive; endproperty
  a_active_sel: assert property (p_active_sel)
    else $error("inactive while selected");
  property p_active_busy; statusByte[STS_BUSY] |-> deviceActive; endproperty
  a_active_busy: assert property (p_active_busy)
    else $error("standby while busy");
  property p_lock_bits;
    $changed({statusByte[7], statusByte[4:2]}) |-> statusByte[0] || $past(statusByte[0]);
  endproperty
  a_lock_bits: assert property (p_lock_bits)
    else $error("protect bits changed outside a cycle");
  c_start: cover property (opStart);
  c_sleep: cover property ($rose(deepSleep));
  c_dual: cover property (lanes.zeroOe);
endmodule

// ### sfcf_host_model.sv
// Host serial controller model for the front end
module sfcf_host_model (
  output logic sclk, // Serial clock, idle low
  output logic csN, // Select, active low
  output logic mosi, // Serial data to device
  input wire sfcf_pkg::sfcf_lanes_t lanes, // Device lanes
  output logic [63:0] rx1, // Lane one capture
  output logic [63:0] rx0, // Lane zero capture
  output logic oeSeen // Any lane enable seen
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfcf_pkg::*;
  // One select pulse at start so the link counters begin cleared
  initial begin
    sclk = 1'b0;
    csN = 1'b0;
    mosi = 1'b0;
    #5 csN = 1'b1;
  end
  // Clock runs only inside a frame; released data line shows inverse
  task automatic frame(input logic [63:0] tx, input int n);
    rx1 = '0;
    rx0 = '0;
    oeSeen = 1'b0;
    csN = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[63 - i];
      #7.5 sclk = 1'b1;
      rx1 = {rx1[62:0], lanes.oneOe ? lanes.oneOut : ~rx1[0]};
      rx0 = {rx0[62:0], lanes.zeroOe ? lanes.zeroOut : ~rx0[0]};
      oeSeen = oeSeen | lanes.oneOe | lanes.zeroOe;
      #7.5 sclk = 1'b0;
    end
    #7.5 csN = 1'b1;
    mosi = ~mosi;
    #600;
  endtask
endmodule

// ### sfcf_front_end_test.sv
// Self-checking bench of the serial flash command front end
module sfcf_front_end_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sfcf_pkg::*;
  typedef struct {logic [63:0] tx; int n; logic [15:0] exp;} sfcf_row_t;
  localparam logic [7:0] MK = 8'hc1; // Arbitrary value
  localparam logic [7:0] DV = 8'h4e; // Arbitrary value
  localparam logic [7:0] MT = 8'h29; // Arbitrary value
  localparam logic [7:0] CP = 8'hb7; // Arbitrary value
  localparam logic [7:0] KEY = 8'h5a;
  logic clk, rst, sclk, csN, mosi, opStart, opDone, deviceActive, deepSleep, oeSeen;
  sfcf_lanes_t lanes;
  sfcf_op_req_t opReq;
  logic [23:0] arrRdAddr;
  logic [7:0] arrRdData, pageRdAddr, pageRdData, statusByte, e1, e0, b;
  logic [63:0] rx1, rx0;
  int nFail = 0, cmpCount = 0, nStart = 0, s0;
  sfcf_row_t rows[7] = '{
    '{{OPC_JEDEC_IDENT, 56'h0}, 32, {MT, CP}},
    '{{OPC_MAKER_DEVICE, 56'h0}, 48, {MK, DV}},
    '{{OPC_MAKER_DEVICE, 24'h000001, 32'h0}, 48, {DV, MK}},
    '{{OPC_WAKE_AND_READ_IDENT_CMD, 56'h0}, 48, {DV, DV}},
    '{{OPC_READ_STATUS, 56'h0}, 24, 16'h0},
    '{{OPC_READ, 24'h000010, 32'h0}, 48, {8'h10 ^ KEY, 8'h11 ^ KEY}},
    '{{OPC_FAST_READ, 24'h000020, 32'h0}, 56, {8'h20 ^ KEY, 8'h21 ^ KEY}}};
  logic [7:0] eop[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  sfcf_op_kind_t ek[5] = '{OPK_ERASE_4K, OPK_ERASE_32K, OPK_ERASE_64K, OPK_ERASE_CHIP,
    OPK_ERASE_CHIP};
  assign arrRdData = arrRdAddr[7:0] ^ KEY;
  sfcf_front_end #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(MT), .CAPACITY(CP))
    sfcf_front_end_inst (.clk, .rst, .sclk, .csN, .serialInLine(mosi), .lanes, .arrRdAddr,
    .arrRdData, .opReq, .opStart, .opDone, .pageRdAddr, .pageRdData, .statusByte,
    .deviceActive, .deepSleep);
  sfcf_host_model sfcf_host_model_inst (.sclk, .csN, .mosi, .lanes, .rx1, .rx0, .oeSeen);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!rst && opStart === 1'b1) nStart <= nStart + 1;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (nFail == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic f(input logic [63:0] tx, input int n);
    sfcf_host_model_inst.frame(tx, n);
  endtask
  task automatic done();
    @(posedge clk) #2 opDone = 1'b1;
    @(posedge clk) #2 opDone = 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Write enable, then the command; optionally check the busy cycle
  task automatic wr(input logic [63:0] tx, input int n, input sfcf_op_kind_t k, input bit ok);
    s0 = nStart;
    f({OPC_WRITE_ENABLE_CMD, 56'h0}, 8);
    f(tx, n);
    chk(nStart - s0, ok);
    if (ok) begin
      chk(opReq.kind, k);
      if (n == 32) chk(opReq.addr, tx[55:32]);
      f({OPC_WRITE_DISABLE, 56'h0}, 8);
      f({OPC_READ_STATUS, 56'h0}, 16);
      chk(rx1[1:0], 2'h3);
      done();
      chk(statusByte[1:0], 2'h0);
    end
  endtask
  initial begin
    #500000;
    nFail++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    opDone = 1'b0;
    pageRdAddr = 8'h0;
    repeat (20) @(posedge clk);
    #2 rst = 1'b0;
    chk({statusByte, deepSleep, deviceActive}, 10'h0);
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      f(rows[i].tx, rows[i].n);
      chk(rx1[15:0], rows[i].exp);
    end
    foreach (eop[i]) wr({eop[i], 24'h123456, 32'h0}, (i > 2) ? 8 : 32, ek[i], 1'b1);
    wr({8'h20, 24'h123456, 32'h0}, 31, OPK_NONE, 1'b0);
    f({OPC_WRITE_DISABLE, 56'h0}, 8);
    s0 = nStart;
    f({OPC_PAGE_PROGRAM_CMD, 24'h0000f0, 32'h0}, 40);
    chk(nStart - s0, 0);
    wr({OPC_STATUS_WRITE_CMD, 8'hff, 48'h0}, 16, OPK_STATUS_WRITE, 1'b1);
    chk(statusByte, 8'h9c);
    wr({OPC_PAGE_PROGRAM_CMD, 24'h0000f0, 8'h3c, 8'hc3, 16'h0}, 48, OPK_PROGRAM, 1'b1);
    chk(opReq.len, 9'h002);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #2 pageRdAddr = 8'hf0 + i[7:0];
      repeat (2) @(posedge clk);
      chk(pageRdData, i ? 8'hc3 : 8'h3c);
    end
    f({OPC_DUAL_READ, 24'h000030, 32'h0}, 48);
    for (int k = 0; k < 8; k++) begin
      b = ((k < 4) ? 8'h30 : 8'h31) ^ KEY;
      e1 = {e1[6:0], b[7 - 2 * (k % 4)]};
      e0 = {e0[6:0], b[6 - 2 * (k % 4)]};
    end
    chk({rx1[7:0], rx0[7:0]}, {e1, e0});
    f({OPC_READ, 24'h0, 32'h0}, 37);
    f({OPC_READ_STATUS, 56'h0}, 16);
    chk(rx1[7:0], 8'h9c);
    f({8'hff, 56'h0}, 24);
    chk(oeSeen, 1'b0);
    f({OPC_ENTER_DEEP_SLEEP_CMD, 56'h0}, 8);
    chk(deepSleep, 1'b1);
    s0 = nStart;
    f({OPC_WRITE_ENABLE_CMD, 56'h0}, 8);
    f({OPC_SECTOR_ERASE_CMD, 56'h0}, 32);
    f({OPC_READ_STATUS, 56'h0}, 16);
    chk({oeSeen, statusByte[1], nStart - s0}, 0);
    f({OPC_WAKE_AND_READ_IDENT_CMD, 56'h0}, 48);
    chk({deepSleep, rx1[7:0]}, {1'b0, DV});
    tally_and_finish();
  end
endmodule
bind sfcf_front_end sfcf_front_end_chk sfcf_front_end_chk_inst (.clk, .rst, .sclk, .csN,
  .serialInLine, .lanes, .arrRdAddr, .arrRdData, .opReq, .opStart, .opDone, .pageRdAddr,
  .pageRdData, .statusByte, .deviceActive, .deepSleep);
